// *** mfa_cfg.svh ***
// constants for the multichannel frame alignment synchroniser
// assumes a single 20 MHz clock and an AXI4-Lite register port
`ifndef MFA_CFG_SVH
`define MFA_CFG_SVH

// ****************************************
// sizes
// ****************************************
`define MFA_CHANNELS 8
`define MFA_GROUPS 7
`define MFA_DEPTH 16
`define MFA_AW 4
`define MFA_MID_ADDR 4'h8

// ****************************************
// group synchroniser counts
// ****************************************
`define MFA_CNT_INIT 5'h12
`define MFA_STEP_ONE 5'h01
`define MFA_STEP_TWO 5'h02

// ****************************************
// register offsets and fields
// ****************************************
`define MFA_CTRL_OFF 5'h00
`define MFA_MIN_OFF 5'h04
`define MFA_STATUS_OFF 5'h08
`define MFA_MASK_OFF 5'h0c
`define MFA_LIVE_OFF 5'h10
`define MFA_CTRL_RESYNC_BIT 0
`define MFA_CTRL_MODE_LSB 1
`define MFA_ST_OOS_LSB 0
`define MFA_ST_GROUP_OVERFLOW_FLAG_LSB 8
`define MFA_ST_OCTAL_GROUP 6
`define MFA_MIN_RESET 4'h2
`define MFA_MASK_RESET 7'h00
`define MFA_RESP_OKAY 2'b00
`define MFA_RESP_SLVERR 2'b10

`endif

// *** mfa_pkg.sv ***
// types shared by the alignment synchroniser files
// constants live in mfa_cfg.svh
package mfa_pkg;
  typedef enum logic [1:0] {
    MFA_SOLO = 2'b00,
    MFA_TWIN = 2'b01,
    MFA_QUAD = 2'b10,
    MFA_OCTAL = 2'b11
  } mfa_mode_t;
endpackage : mfa_pkg

// *** mfa_align_fifo.sv ***
// one channel's alignment fifo with pointer placement and overflow check
// assumes framer pulses and data arrive on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "mfa_cfg.svh"
module mfa_align_fifo (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic arm,
  input wire logic solo,
  input wire logic fp_in,
  input wire logic wr_en,
  input wire logic [31:0] wr_data,
  input wire logic grp_start,
  input wire logic [3:0] fifo_min,
  output logic [32:0] rd_word,
  output logic rd_valid,
  output logic reading,
  output logic group_overflow_flag_pulse
);
  logic [32:0] mem [0:`MFA_DEPTH-1];
  logic [3:0] wr_ptr_reg;
  logic [3:0] rd_ptr_reg;
  logic placed_reg;
  logic first_fp;

  assign first_fp = fp_in && !placed_reg;

  // write at start on first pulse
  always_ff @(posedge clk) begin
    if (first_fp) begin
      mem[4'h0] <= {1'b1, wr_data};
    end else if (placed_reg && wr_en) begin
      mem[wr_ptr_reg] <= {fp_in, wr_data};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      placed_reg <= 1'b0;
      wr_ptr_reg <= 4'h0;
    end else if (arm) begin
      placed_reg <= 1'b0;
      wr_ptr_reg <= 4'h0;
    end else if (first_fp) begin
      placed_reg <= 1'b1;
      wr_ptr_reg <= 4'h1;
    end else if (placed_reg && wr_en) begin
      wr_ptr_reg <= wr_ptr_reg + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reading <= 1'b0;
      rd_ptr_reg <= 4'h0;
      rd_valid <= 1'b0;
      rd_word <= 33'h0_0000_0000;
    end else if (arm) begin
      reading <= 1'b0;
      rd_ptr_reg <= 4'h0;
      rd_valid <= 1'b0;
    end else if (first_fp && solo) begin
      reading <= 1'b1;
      rd_ptr_reg <= `MFA_MID_ADDR;
      rd_valid <= 1'b0;
    end else if (grp_start && !solo) begin
      // every member wrote its frame word at zero, so all start together
      reading <= 1'b1;
      rd_ptr_reg <= 4'h0;
      rd_valid <= 1'b0;
    end else if (reading && rd_ptr_reg != wr_ptr_reg) begin
      rd_word <= mem[rd_ptr_reg];
      rd_valid <= 1'b1;
      rd_ptr_reg <= rd_ptr_reg + 4'h1;
    end else begin
      rd_valid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      group_overflow_flag_pulse <= 1'b0;
    end else begin
      group_overflow_flag_pulse <= fp_in && placed_reg && reading && !arm
                    && (rd_ptr_reg < fifo_min);
    end
  end
endmodule : mfa_align_fifo
`default_nettype wire

// *** mfa_group_sync.sv ***
// down counter synchroniser for one alignment group
// assumes member pulses are single-cycle and on this clock
`timescale 1ns/1ps
`default_nettype none
`include "mfa_cfg.svh"
module mfa_group_sync (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic arm,
  input wire logic enable,
  input wire logic [7:0] member,
  input wire logic [7:0] fp_vec,
  output logic start_pulse,
  output logic oos_pulse
);
  logic [4:0] cnt_reg;
  logic [7:0] seen_reg;
  logic done_reg;
  logic [7:0] seen_next;
  logic all_seen;

  assign seen_next = seen_reg | (fp_vec & member);
  assign all_seen = (seen_next == member);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= `MFA_CNT_INIT;
      seen_reg <= 8'h00;
      done_reg <= 1'b0;
      start_pulse <= 1'b0;
      oos_pulse <= 1'b0;
    end else if (arm || !enable) begin
      cnt_reg <= `MFA_CNT_INIT;
      seen_reg <= 8'h00;
      done_reg <= 1'b0;
      start_pulse <= 1'b0;
      oos_pulse <= 1'b0;
    end else begin
      seen_reg <= seen_next;
      start_pulse <= 1'b0;
      oos_pulse <= 1'b0;
      if (!done_reg && seen_reg != 8'h00) begin
        if (cnt_reg == 5'h00) begin
          done_reg <= 1'b1;
          start_pulse <= all_seen;
          oos_pulse <= !all_seen;
        end else if (all_seen) begin
          cnt_reg <= (cnt_reg < `MFA_STEP_TWO) ? 5'h00
                     : cnt_reg - `MFA_STEP_TWO;
        end else begin
          cnt_reg <= cnt_reg - `MFA_STEP_ONE;
        end
      end
    end
  end
endmodule : mfa_group_sync
`default_nettype wire

// *** mfa_align_top.sv ***
// multichannel frame alignment synchroniser with AXI4-Lite registers
// assumes all channel data and framing marks are on clk
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "mfa_cfg.svh"
module mfa_align_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [255:0] ch_data,
  input wire logic [7:0] ch_valid,
  input wire logic [7:0] ch_frame_word,
  output logic [255:0] out_data,
  output logic [7:0] out_valid,
  output logic [7:0] out_frame_start,
  output logic irq,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ****************************************
  // registers
  // ****************************************
  mfa_pkg::mfa_mode_t mode_reg;
  logic resync_reg;
  logic [3:0] fifo_min_reg;
  logic [6:0] group_out_of_sync_flag;
  logic [6:0] group_overflow_flag;
  logic [6:0] oos_mask_reg;
  logic [6:0] group_overflow_flag_mask_reg;

  // ****************************************
  // bus slave state
  // ****************************************
  logic aw_held_reg;
  logic w_held_reg;
  logic [4:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic do_write;
  logic wr_ctrl;
  logic wr_min;
  logic wr_status;
  logic wr_mask;
  logic [6:0] clr_oos;
  logic [6:0] clr_group_overflow_flag;

  // ****************************************
  // datapath wires
  // ****************************************
  logic [7:0] fp_vec;
  logic [7:0] ch_reading;
  logic [7:0] ch_group_overflow_flag;
  logic [7:0] ch_start;
  logic [6:0] grp_start;
  logic [6:0] grp_oos;
  logic [6:0] grp_enable;
  logic [6:0] grp_group_overflow_flag;
  logic [7:0] grp_member [0:`MFA_GROUPS-1];
  logic solo;
  logic arm;
  logic [32:0] rd_word [0:`MFA_CHANNELS-1];
  logic [7:0] rd_valid;
  logic [6:0] oos_set;
  logic [6:0] group_overflow_flag_set;

  // ****************************************
  // frame pulses
  // ****************************************
  // pulse on framing word
  assign fp_vec = ch_valid & ch_frame_word;
  assign solo = (mode_reg == mfa_pkg::MFA_SOLO);
  assign arm = resync_reg;

  // ****************************************
  // group membership
  // ****************************************
  // pairs, quads and the octal group
  always_comb begin
    for (int g = 0; g < `MFA_GROUPS; g++) begin
      if (g < 4) begin
        grp_member[g] = 8'h03 << (2 * g);
        grp_enable[g] = (mode_reg == mfa_pkg::MFA_TWIN);
      end else if (g < 6) begin
        grp_member[g] = 8'h0f << (4 * (g - 4));
        grp_enable[g] = (mode_reg == mfa_pkg::MFA_QUAD);
      end else begin
        grp_member[g] = 8'hff;
        grp_enable[g] = (mode_reg == mfa_pkg::MFA_OCTAL);
      end
    end
  end

  always_comb begin
    ch_start = 8'h00;
    for (int g = 0; g < `MFA_GROUPS; g++) begin
      grp_group_overflow_flag[g] = grp_enable[g] && ((ch_group_overflow_flag & grp_member[g]) != 8'h00);
      if (grp_start[g]) begin
        ch_start = ch_start | grp_member[g];
      end
    end
  end

  // one synchroniser per possible group; only the mode's groups count
  genvar gi;
  generate
    for (gi = 0; gi < `MFA_GROUPS; gi++) begin : g_grp
      mfa_group_sync u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .arm(arm),
        .enable(grp_enable[gi]),
        .member(grp_member[gi]),
        .fp_vec(fp_vec),
        .start_pulse(grp_start[gi]),
        .oos_pulse(grp_oos[gi])
      );
    end
    for (gi = 0; gi < `MFA_CHANNELS; gi++) begin : g_ch
      mfa_align_fifo u_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .arm(arm),
        .solo(solo),
        .fp_in(fp_vec[gi]),
        .wr_en(ch_valid[gi]),
        .wr_data(ch_data[gi*32 +: 32]),
        .grp_start(ch_start[gi]),
        .fifo_min(fifo_min_reg),
        .rd_word(rd_word[gi]),
        .rd_valid(rd_valid[gi]),
        .reading(ch_reading[gi]),
        .group_overflow_flag_pulse(ch_group_overflow_flag[gi])
      );
    end
  endgenerate

  // ****************************************
  // aligned output to fabric
  // ****************************************
  // flag bit rides with its word, so the frame mark stays aligned
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_data <= 256'h0;
      out_valid <= 8'h00;
      out_frame_start <= 8'h00;
    end else begin
      for (int c = 0; c < `MFA_CHANNELS; c++) begin
        out_data[c*32 +: 32] <= rd_word[c][31:0];
        out_valid[c] <= rd_valid[c];
        out_frame_start[c] <= rd_valid[c] && rd_word[c][32];
      end
    end
  end

  // ****************************************
  // write channel
  // ****************************************
  // out-of-range writes get an error answer and change nothing
  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_ctrl = do_write && (awaddr_reg == `MFA_CTRL_OFF);
  assign wr_min = do_write && (awaddr_reg == `MFA_MIN_OFF);
  assign wr_status = do_write && (awaddr_reg == `MFA_STATUS_OFF);
  assign wr_mask = do_write && (awaddr_reg == `MFA_MASK_OFF);
  assign clr_oos = wr_status && wstrb_reg[0]
                   ? wdata_reg[`MFA_ST_OOS_LSB +: 7] : 7'h00;
  assign clr_group_overflow_flag = wr_status && wstrb_reg[1]
                    ? wdata_reg[`MFA_ST_GROUP_OVERFLOW_FLAG_LSB +: 7] : 7'h00;

  // address and data taken in either order, one write at a time
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 5'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MFA_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awready && s_axi_awvalid) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= {s_axi_awaddr[4:2], 2'b00};
      end
      if (s_axi_wready && s_axi_wvalid) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_reg > `MFA_LIVE_OFF)
                       ? `MFA_RESP_SLVERR : `MFA_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  // resync is a one-cycle command, never stored
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_reg <= mfa_pkg::MFA_SOLO;
      resync_reg <= 1'b0;
    end else begin
      resync_reg <= wr_ctrl && wstrb_reg[0]
                    && wdata_reg[`MFA_CTRL_RESYNC_BIT];
      if (wr_ctrl && wstrb_reg[0]) begin
        mode_reg <= mfa_pkg::mfa_mode_t'(wdata_reg[`MFA_CTRL_MODE_LSB +: 2]);
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fifo_min_reg <= `MFA_MIN_RESET;
    end else if (wr_min && wstrb_reg[0]) begin
      fifo_min_reg <= wdata_reg[3:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      oos_mask_reg <= `MFA_MASK_RESET;
      group_overflow_flag_mask_reg <= `MFA_MASK_RESET;
    end else if (wr_mask) begin
      if (wstrb_reg[0]) begin
        oos_mask_reg <= wdata_reg[`MFA_ST_OOS_LSB +: 7];
      end
      if (wstrb_reg[1]) begin
        group_overflow_flag_mask_reg <= wdata_reg[`MFA_ST_GROUP_OVERFLOW_FLAG_LSB +: 7];
      end
    end
  end

  // ****************************************
  // sticky status and interrupt
  // ****************************************
  assign oos_set = grp_oos;
  assign group_overflow_flag_set = grp_group_overflow_flag;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      group_out_of_sync_flag <= 7'h00;
    end else begin
      group_out_of_sync_flag <= (group_out_of_sync_flag & ~clr_oos) | oos_set;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      group_overflow_flag <= 7'h00;
    end else begin
      group_overflow_flag <= (group_overflow_flag & ~clr_group_overflow_flag) | group_overflow_flag_set;
    end
  end

  // one cycle behind the flags so the pin comes from a flop
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= ((group_out_of_sync_flag & oos_mask_reg) != 7'h00)
             || ((group_overflow_flag & group_overflow_flag_mask_reg) != 7'h00);
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  // ready is a one-cycle pulse, so a held arvalid is taken only once
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `MFA_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `MFA_RESP_OKAY;
        unique case ({s_axi_araddr[4:2], 2'b00})
          `MFA_CTRL_OFF: s_axi_rdata <= {29'h0, mode_reg, 1'b0};
          `MFA_MIN_OFF: s_axi_rdata <= {28'h0, fifo_min_reg};
          `MFA_STATUS_OFF: s_axi_rdata <= {17'h0, group_overflow_flag,
                                           1'b0, group_out_of_sync_flag};
          `MFA_MASK_OFF: s_axi_rdata <= {17'h0, group_overflow_flag_mask_reg,
                                         1'b0, oos_mask_reg};
          `MFA_LIVE_OFF: s_axi_rdata <= {24'h0, ch_reading};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `MFA_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : mfa_align_top
`default_nettype wire

// *** mfa_align_checker.sv ***
// port assertions for mfa_align_top
// assumes it is bound onto mfa_align_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "mfa_cfg.svh"
module mfa_align_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] ch_valid,
  input wire logic [7:0] ch_frame_word,
  input wire logic [7:0] out_valid,
  input wire logic [7:0] out_frame_start,
  input wire logic irq,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ****
  // helper state
  // ****
  logic [7:0] seen_reg;
  logic [4:0] raddr_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seen_reg <= 8'h00;
    end else begin
      seen_reg <= seen_reg | (ch_valid & ch_frame_word);
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      raddr_reg <= 5'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      raddr_reg <= s_axi_araddr;
    end
  end
  sequence wr_offer;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  endsequence
  sequence wr_answer;
    ##[1:8] s_axi_bvalid;
  endsequence
  AST_FRAME_MARK_WITH_WORD: assert property (
    (out_frame_start & ~out_valid) == 8'h00)
    else $error("frame start without a word");
  // no channel reads before its first pulse
  AST_NO_OUTPUT_UNARMED: assert property (
    (out_valid & ~seen_reg) == 8'h00)
    else $error("output before first frame pulse");
  AST_IRQ_CLEAR_BY_WRITE: assert property (
    $fell(irq) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("irq dropped without a write");
  AST_READ_ANSWER: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_AR_PULSE: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready held");
  AST_R_ONCE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid after handshake");
  AST_B_ONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid after handshake");
  AST_UNMAPPED_READ: assert property (
    s_axi_rvalid && raddr_reg > `MFA_LIVE_OFF |->
      s_axi_rresp == `MFA_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  AST_WRITE_ANSWERED: assert property (wr_offer |-> wr_answer)
    else $error("write not answered");
endmodule : mfa_align_checker
`default_nettype wire

// *** mfa_fabric_model.sv ***
// fabric consumer of aligned words: records arrival per channel
// assumes registered out_* pulses; there is no backpressure path
`timescale 1ns/1ps
`default_nettype none
module mfa_fabric_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic [255:0] out_data,
  input wire logic [7:0] out_valid,
  input wire logic [7:0] out_frame_start,
  output logic [31:0] first_at [8],
  output logic [31:0] start_word [8],
  output logic [15:0] words [8]
);
  int now = 0;
  // first framing word kept; later ones are repeat frames
  always @(posedge clk) begin
    now = now + 1;
    for (int c = 0; c < 8; c++) begin
      if (clear || !reset_n) begin
        words[c] = 16'h0000;
        first_at[c] = 32'h0000_0000;
        start_word[c] = 32'h0000_0000;
      end else if (out_valid[c]) begin
        if (words[c] == 16'h0000) first_at[c] = now;
        if (out_frame_start[c] && start_word[c] == 32'h0000_0000)
          start_word[c] = out_data[c*32 +: 32];
        words[c] = words[c] + 16'h0001;
      end
    end
  end
endmodule : mfa_fabric_model
`default_nettype wire

// *** test_multichannel_frame_alignment_sync.sv ***
// self-checking bench for mfa_align_top
// assumes the checker and fabric model files compile first
`timescale 1ns/1ps
`default_nettype none
`include "mfa_cfg.svh"
module test_multichannel_frame_alignment_sync;
  localparam int NV = 255;
  typedef struct {
    logic [1:0] mode;
    logic [3:0] min;
    int d [8];
    bit ex;
    logic [15:0] st;
  } mfa_row_t;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic clear = 1'b0;
  logic [255:0] ch_data = 256'h0;
  logic [7:0] ch_valid = 8'h00;
  logic [7:0] ch_frame_word = 8'h00;
  logic [255:0] out_data;
  logic [7:0] out_valid, out_frame_start;
  logic irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [4:0] s_axi_awaddr = 5'h00;
  logic [4:0] s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] first_at [8];
  logic [31:0] start_word [8];
  logic [15:0] words [8];
  int failures = 0;
  int checked = 0;
  int dly [8];
  bit extra;
  mfa_row_t rows [9];
  always #25 clk = ~clk;
  mfa_align_top dut (.*);
  mfa_fabric_model fabric (.*);
  // ****
  // shared tasks
  // ****
  task automatic summarize;
    if (failures == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    chk("rdata", e, s_axi_rdata);
  endtask : rd
  // framing word at 4 + lag; optional repeat frames for overflow
  task automatic stream(input int len);
    for (int i = 0; i < len; i++) begin
      @(posedge clk);
      for (int c = 0; c < 8; c++) begin
        ch_data[c*32 +: 32] <= {8'(c), 8'h00, 16'(i)};
        ch_frame_word[c] <= i == 4 + dly[c] ||
          (extra && (i == 24 + dly[c] || i == 31 + dly[c]));
      end
      ch_valid <= 8'hff;
    end
    @(posedge clk);
    ch_valid <= 8'h00;
    ch_frame_word <= 8'h00;
  endtask : stream
  task automatic do_row(input int k, input bit irq_on);
    mfa_row_t r;
    logic [7:0] live;
    int g, m, si;
    r = rows[k];
    dly = r.d;
    extra = r.ex;
    wr(`MFA_MIN_OFF, {28'h000_0000, r.min}, `MFA_RESP_OKAY);
    wr(`MFA_CTRL_OFF, {29'h0, r.mode, 1'b1}, `MFA_RESP_OKAY);
    wr(`MFA_STATUS_OFF, 32'h0000_7f7f, `MFA_RESP_OKAY);
    rd(`MFA_CTRL_OFF, {29'h0, r.mode, 1'b0}, `MFA_RESP_OKAY);
    @(posedge clk) clear <= 1'b1;
    @(posedge clk) clear <= 1'b0;
    stream(48);
    repeat (30) @(posedge clk);
    rd(`MFA_STATUS_OFF, {16'h0000, r.st}, `MFA_RESP_OKAY);
    live = 8'h00;
    for (int c = 0; c < 8; c++) begin
      g = c >> r.mode;
      m = 1;
      for (int j = 0; j < 8; j++) if ((j >> r.mode) == g && r.d[j] == NV) m = 0;
      // a group flagged out of sync never starts reading
      si = (r.mode == 2'h1) ? g : (r.mode == 2'h2) ? 4 + g : 6;
      if (r.mode != 2'h0 && r.st[si] == 1'b1) m = 0;
      if (m == 1) begin
        live[c] = 1'b1;
        chk("start word", {8'(c), 8'h00, 16'(4 + r.d[c])}, start_word[c]);
        if (r.mode != 2'h0) chk("aligned", first_at[g << r.mode], first_at[c]);
      end else chk("no read", 32'h0, {16'h0, words[c]});
    end
    rd(`MFA_LIVE_OFF, {24'h0, live}, `MFA_RESP_OKAY);
    chk("irq", {31'h0, irq_on && r.st != 16'h0000}, {31'h0, irq});
    wr(`MFA_STATUS_OFF, {16'h0, r.st}, `MFA_RESP_OKAY);
    repeat (3) @(posedge clk);
    chk("irq clear", 32'h0, {31'h0, irq});
    rd(`MFA_STATUS_OFF, 32'h0, `MFA_RESP_OKAY);
  endtask : do_row
  // ****
  // main sequence
  // ****
  initial begin
    rows = '{
      '{2'h0, 4'h2, '{0, 1, 2, 3, 4, 5, 6, 7}, 0, 16'h0000},
      '{2'h1, 4'h2, '{0, 3, 0, NV, NV, NV, NV, NV}, 0, 16'h0002},
      '{2'h1, 4'h2, '{0, 25, NV, NV, NV, NV, NV, NV}, 0, 16'h0001},
      '{2'h1, 4'h2, '{NV, 0, 0, NV, NV, NV, NV, NV}, 0, 16'h0003},
      '{2'h2, 4'h2, '{2, 0, 5, 1, 0, 0, 0, NV}, 0, 16'h0020},
      '{2'h3, 4'h2, '{0, 1, 2, 3, 4, 5, 6, 7}, 0, 16'h0000},
      '{2'h3, 4'h2, '{0, 0, 0, 0, 0, 0, 0, NV}, 0, 16'h0040},
      '{2'h1, 4'hf, '{0, 0, NV, NV, NV, NV, NV, NV}, 1, 16'h0100},
      '{2'h1, 4'h0, '{0, 0, NV, NV, NV, NV, NV, NV}, 1, 16'h0000}};
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    wr(`MFA_MASK_OFF, 32'h0000_7f7f, `MFA_RESP_OKAY);
    for (int k = 0; k < 9; k++) do_row(k, 1'b1);
    // masked events leave irq low
    wr(`MFA_MASK_OFF, 32'h0000_0000, `MFA_RESP_OKAY);
    do_row(1, 1'b0);
    wr(5'h14, 32'h0000_0001, `MFA_RESP_SLVERR);
    wr(`MFA_MIN_OFF, 32'h0000_0005, `MFA_RESP_OKAY);
    @(posedge clk) reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 6; i++) rd(5'(4 * i), i == 1 ? 32'h2 : 32'h0, i == 5 ? `MFA_RESP_SLVERR : `MFA_RESP_OKAY);
    chk("irq reset", 32'h0, {31'h0, irq});
    summarize;
  end
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    summarize;
  end
endmodule : test_multichannel_frame_alignment_sync
bind mfa_align_top mfa_align_checker chk_i (.*);
`default_nettype wire
